/* verilog/bpsp_pkg.sv */
// Package for the protection and speed-pulse block: counts, widths, states.
// Assumes a single 200 MHz ref_clk domain and a synchronous active-high reset.
package bpsp_pkg;
  localparam int CLK_MHZ          = 200;
  localparam int FILT_CYCLES      = 5;
  localparam int CARRIER_DIV      = 252;
  localparam int RUN_TIME_S       = 5;
  localparam int STOP_TIME_S      = 30;
  // A 30 s stop at 200 MHz does not fit in 32 bits
  localparam longint RUN_TICKS    = longint'(RUN_TIME_S) * CLK_MHZ * 1000000;
  localparam longint STOP_TICKS   = longint'(STOP_TIME_S) * CLK_MHZ * 1000000;
  localparam int ANGLE_W          = 5;
  localparam int ANGLE_MAX_DEG    = 58;
  localparam int DEG_W            = 6;
  localparam logic [2:0] PPR_THREE = 3'h3;
  localparam logic [2:0] PPR_ONE   = 3'h1;
  localparam logic [2:0] CNT_RST   = 3'h0;
  // Synchroniser reset: sense open and rate select start at their safe level
  localparam logic [4:0] SYNC_RST  = 5'h12;
  typedef enum logic [1:0] {BPSP_RUN, BPSP_TRIP, BPSP_STALL} bpsp_state_e;
endpackage

/* verilog/bpsp_if.sv */
// Interface carrying the filter handshake between top and filter.
// Assumes both ends on ref_clk.
interface bpsp_filt_if;
  logic raw;
  logic accepted;
  modport top (output raw, input accepted);
  modport filt (input raw, output accepted);
endinterface

/* verilog/bpsp_filter.sv */
// Persistence filter for the over-current comparator level.
// Assumes the input is already synchronised to ref_clk.
module bpsp_filter #(
  parameter int N = 5
) (
  input  wire logic ref_clk,
  input  wire logic srst,
  bpsp_filt_if.filt f
);
  import bpsp_pkg::*;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic       acc_reg;
  logic       acc_next;
  always_comb begin
    cnt_next = 4'h0;
    acc_next = 1'b0;
    if (f.raw) begin
      if (cnt_reg >= 4'(N - 1)) begin
        cnt_next = cnt_reg;
        acc_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + 4'h1;
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cnt_reg <= 4'h0;
      acc_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      acc_reg <= acc_next;
    end
  end
  assign f.accepted = acc_reg;
endmodule

/* verilog/bpsp_top.sv */
// Top of the protection, stall-stop, lead clip and speed-pulse logic.
// Assumes comparator levels and hall edge events arrive from outside ref_clk.
module bpsp_top
  import bpsp_pkg::*;
#(
  parameter longint RUN_CYC  = bpsp_pkg::RUN_TICKS,
  parameter longint STOP_CYC = bpsp_pkg::STOP_TICKS,
  parameter int     CAR_DIV  = bpsp_pkg::CARRIER_DIV
) (
  input  wire logic                        ref_clk,
  input  wire logic                        srst,
  input  wire logic [5:0]                  comm_in,
  input  wire logic                        overcurrent_in,
  input  wire logic                        sense_open_in,
  input  wire logic                        hall_edge_in,
  input  wire logic                        rev_mark_in,
  input  wire logic                        pulse_rate_select,
  input  wire logic [bpsp_pkg::ANGLE_W-1:0] advance_angle_in,
  input  wire logic [bpsp_pkg::ANGLE_W-1:0] lead_upper_limit,
  output logic      [5:0]                  comm_out,
  output logic                             speed_pulse_out,
  output logic      [bpsp_pkg::DEG_W-1:0]  lead_angle_deg,
  output logic                             stall_detect_cap
);
  import bpsp_pkg::*;

  // Timer sized from the longer interval; the full 30 s stop needs 33 bits
  localparam longint TMR_MAX = (RUN_CYC > STOP_CYC) ? RUN_CYC : STOP_CYC;
  localparam int     TMR_W   = $clog2(TMR_MAX + 1);
  bpsp_filt_if fi ();
  logic [4:0]         s1_reg;
  logic [4:0]         s1_next;
  logic [4:0]         s2_reg;
  logic [4:0]         s2_next;
  logic [1:0]         e_reg;
  logic [1:0]         e_next;
  bpsp_state_e        st_reg;
  bpsp_state_e        st_next;
  logic [7:0]         car_reg;
  logic [7:0]         car_next;
  logic [TMR_W-1:0]   tmr_reg;
  logic [TMR_W-1:0]   tmr_next;
  logic [5:0]         out_reg;
  logic [5:0]         out_next;
  logic               fg_reg;
  logic               fg_next;
  logic [5:0]         deg_reg;
  logic [5:0]         deg_next;
  logic               car_end;
  logic               hall_rise;
  logic               hall_chg;
  logic               rev_chg;
  logic               open_s;
  logic               rate_three;
  logic               run_expired;
  logic               stop_expired;
  logic [ANGLE_W-1:0] clip;

  bpsp_filter #(.N(FILT_CYCLES)) u_filt (
    .ref_clk (ref_clk),
    .srst    (srst),
    .f       (fi.filt)
  );

  // Two-flop synchronisers; edge logic reads only the second stage
  // Sense-open and rate-select stages reset high, so an open sense pin
  // cannot pass commutation while the synchroniser is still filling
  always_comb begin
    s1_next = {pulse_rate_select, rev_mark_in, hall_edge_in, sense_open_in, overcurrent_in};
    s2_next = s1_reg;
    e_next  = s2_reg[3:2];
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s1_reg <= SYNC_RST;
      s2_reg <= SYNC_RST;
      e_reg  <= 2'h0;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      e_reg  <= e_next;
    end
  end

  assign fi.raw       = s2_reg[0];
  assign open_s       = s2_reg[1];
  assign rate_three   = s2_reg[4];
  assign hall_rise    = s2_reg[2] & ~e_reg[0];
  assign hall_chg     = s2_reg[2] ^ e_reg[0];
  assign rev_chg      = s2_reg[3] ^ e_reg[1];
  assign car_end      = (car_reg == 8'(CAR_DIV - 1));
  assign run_expired  = (tmr_reg >= TMR_W'(RUN_CYC - 1));
  assign stop_expired = (tmr_reg >= TMR_W'(STOP_CYC - 1));
  assign clip         = (advance_angle_in > lead_upper_limit) ? lead_upper_limit
                                                              : advance_angle_in;

  // Free-running carrier counter; its period sets when a trip may release
  always_comb begin
    car_next = car_end ? 8'h00 : car_reg + 8'h01;
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      car_reg <= 8'h00;
    end else begin
      car_reg <= car_next;
    end
  end

  // Stall timer runs while driving and through the stall stop; a trip clears it, so a long trip
  // is not mistaken for a restrained rotor
  always_comb begin
    st_next  = st_reg;
    tmr_next = tmr_reg;
    unique case (st_reg)
      BPSP_RUN: begin
        if (fi.accepted) begin
          st_next = BPSP_TRIP;
        end
        if (hall_rise) begin
          tmr_next = '0;
        end else if (run_expired) begin
          st_next  = BPSP_STALL;
          tmr_next = '0;
        end else begin
          tmr_next = tmr_reg + TMR_W'(1);
        end
      end
      BPSP_TRIP: begin
        tmr_next = '0;
        if (car_end && !fi.accepted) begin
          st_next = BPSP_RUN;
        end
      end
      BPSP_STALL: begin
        if (stop_expired) begin
          st_next  = BPSP_RUN;
          tmr_next = '0;
        end else begin
          tmr_next = tmr_reg + TMR_W'(1);
        end
      end
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_reg  <= BPSP_RUN;
      tmr_reg <= '0;
    end else begin
      st_reg  <= st_next;
      tmr_reg <= tmr_next;
    end
  end

  // Forced-low has priority over commutation; open sense disables all
  // The accepted flag gates at once, a cycle before the trip state shows
  always_comb begin
    out_next = comm_in;
    if (st_reg != BPSP_RUN || fi.accepted) begin
      out_next = 6'h00;
    end
    if (open_s) begin
      out_next = 6'h00;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      out_reg <= 6'h00;
    end else begin
      out_reg <= out_next;
    end
  end

  // One marker is one full pulse: the output toggles on both of its edges
  // Markers shorter than one clock may be lost in the synchroniser
  always_comb begin
    fg_next = fg_reg;
    if (rate_three) begin
      if (hall_chg) begin
        fg_next = ~fg_reg;
      end
    end else begin
      if (rev_chg) begin
        fg_next = ~fg_reg;
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      fg_reg <= 1'b0;
    end else begin
      fg_reg <= fg_next;
    end
  end

  // Degrees = code*58/31, so the full code lands on 58 with no extra clamp
  always_comb begin
    deg_next = 6'((11'(clip) * 11'(ANGLE_MAX_DEG)) / 11'((1 << ANGLE_W) - 1));
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      deg_reg <= 6'h00;
    end else begin
      deg_reg <= deg_next;
    end
  end

  // Stall flag comes straight from the state register
  assign comm_out         = out_reg;
  assign speed_pulse_out  = fg_reg;
  assign lead_angle_deg   = deg_reg;
  assign stall_detect_cap = (st_reg == BPSP_STALL);
endmodule

/* testbench/bpsp_top_sva.sv */
// Port checker for bpsp_top, bound to every instance.
// Assumes srst synchronous, active high, on ref_clk.
module bpsp_top_sva
  import bpsp_pkg::*;
#(
  parameter longint RUN_CYC  = 200,
  parameter longint STOP_CYC = 600,
  parameter int     CAR_DIV  = 252
) (
  input wire logic                          ref_clk,
  input wire logic                          srst,
  input wire logic [5:0]                    comm_in,
  input wire logic                          overcurrent_in,
  input wire logic                          sense_open_in,
  input wire logic                          hall_edge_in,
  input wire logic                          rev_mark_in,
  input wire logic                          pulse_rate_select,
  input wire logic [bpsp_pkg::ANGLE_W-1:0]  advance_angle_in,
  input wire logic [bpsp_pkg::ANGLE_W-1:0]  lead_upper_limit,
  input wire logic [5:0]                    comm_out,
  input wire logic                          speed_pulse_out,
  input wire logic [bpsp_pkg::DEG_W-1:0]    lead_angle_deg,
  input wire logic                          stall_detect_cap
);
  logic [4:0] lead_min;
  assign lead_min = (advance_angle_in < lead_upper_limit) ? advance_angle_in : lead_upper_limit;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  AST_TRIP: assert property (overcurrent_in[*8] |=> comm_out == 6'h00)
    else $error("over-current did not force outputs low");
  AST_OPEN: assert property (sense_open_in[*4] |-> comm_out == 6'h00)
    else $error("open sense left outputs active");
  AST_PASS: assert property (comm_out != 6'h00 |-> comm_out == $past(comm_in))
    else $error("commutation not passed through");
  AST_STALL: assert property (stall_detect_cap[*2] |-> comm_out == 6'h00)
    else $error("outputs active during stall stop");
  AST_STOP: assert property ($rose(stall_detect_cap) |=> stall_detect_cap[*8])
    else $error("stall stop too short");
  AST_LEAD: assert property (1'b1 |=> lead_angle_deg == 6'(($past(lead_min) * 58) / 31))
    else $error("lead angle not clipped and scaled");
  AST_MAX: assert property (lead_angle_deg <= 6'h3a)
    else $error("lead angle above full scale");
  AST_PULSE: assert property ((!hall_edge_in && !rev_mark_in)[*6] |=> $stable(speed_pulse_out))
    else $error("speed pulse moved without an event");
endmodule
bind bpsp_top bpsp_top_sva #(.RUN_CYC(RUN_CYC), .STOP_CYC(STOP_CYC), .CAR_DIV(CAR_DIV)) i_bpsp_top_sva (.*);

/* testbench/bpsp_motor.sv */
// Motor model: hall markers, every third one also a revolution mark.
// Assumes ref_clk; markers stay low while stopped, so a stall can be staged.
module bpsp_motor (
  input  wire logic ref_clk,
  input  wire logic run,
  output logic      hall_edge_in = 1'h0,
  output logic      rev_mark_in = 1'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  int n = 0;
  always @(posedge ref_clk) begin
    n <= run ? (n + 1) % 36 : 0;
    hall_edge_in <= #1 run && (n % 12 < 4);
    rev_mark_in <= #1 run && (n < 4);
  end
endmodule

/* testbench/bpsp_tb_top.sv */
// Bench for bpsp_top with the motor model; expectations worked out here.
// Assumes 200 MHz ref_clk and shortened stall counts.
module bpsp_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import bpsp_pkg::*;
  logic ref_clk = 1'h0, srst = 1'h1, overcurrent_in = 1'h0, sense_open_in = 1'h1, run = 1'h1;
  logic pulse_rate_select = 1'h1, hall_edge_in, rev_mark_in, speed_pulse_out, stall_detect_cap;
  logic [5:0] comm_in = 6'h3f, comm_out, lead_angle_deg;
  logic [4:0] advance_angle_in = 5'h00, lead_upper_limit = 5'h00;
  logic [7:0] lfsr = 8'h49;
  int errors = 0, checked = 0, nh, nr, nt, m;
  bpsp_top #(.RUN_CYC(200), .STOP_CYC(600)) i_bpsp_top (.*);
  bpsp_motor i_bpsp_motor (.*);
  initial forever #2.5 ref_clk = ~ref_clk;
  always @(posedge hall_edge_in) nh++;
  always @(posedge rev_mark_in) nr++;
  always @(speed_pulse_out) nt++;
  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    end_of_test();
  end
  initial begin
    cyc(5);
    srst = 1'h0;
    cyc(2);
    chk(comm_out, 6'h00);
    sense_open_in = 1'h0;
    cyc(2);
    for (int i = 0; i < 24; i++) begin
      lfsr = lfsr_next(lfsr);
      advance_angle_in = (i == 0) ? 5'h1f : lfsr[4:0];
      lead_upper_limit = (i < 2) ? 5'h1f : lfsr[7:3];
      comm_in = lfsr[5:0];
      cyc(2);
      m = (advance_angle_in < lead_upper_limit) ? advance_angle_in : lead_upper_limit;
      chk(lead_angle_deg, m * 58 / 31);
      chk(comm_out, comm_in);
    end
    for (int s = 1; s >= 0; s--) begin
      pulse_rate_select = s[0];
      run = 1'h0;
      cyc(20);
      nh = 0;
      nr = 0;
      nt = 0;
      run = 1'h1;
      cyc(108);
      run = 1'h0;
      cyc(10);
      chk(nt, 2 * (s ? nh : nr));
      chk(nt, s ? 6 * nr : 2 * nr);
    end
    run = 1'h1;
    comm_in = 6'h3f;
    overcurrent_in = 1'h1;
    cyc(4);
    overcurrent_in = 1'h0;
    cyc(8);
    chk(comm_out, 6'h3f);
    overcurrent_in = 1'h1;
    cyc(10);
    chk(comm_out, 6'h00);
    overcurrent_in = 1'h0;
    cyc(CARRIER_DIV + 12);
    chk(comm_out, 6'h3f);
    sense_open_in = 1'h1;
    cyc(4);
    chk(comm_out, 6'h00);
    sense_open_in = 1'h0;
    cyc(CARRIER_DIV + 12);
    run = 1'h0;
    cyc(260);
    chk(stall_detect_cap, 1'h1);
    chk(comm_out, 6'h00);
    cyc(600);
    chk(stall_detect_cap, 1'h0);
    end_of_test();
  end
endmodule
